/* File: flash_access_mode_control.sv */
// Notes on behaviour
// - Reset always returns the access-size field to 10, read-only mode.
// - Field 10: read-only mode, word reads and instruction fetch accepted.
// - Field 01: programming mode, half-word reads and writes accepted.
// - Read-only mode refuses command writes with an error; no program or erase job starts.
// - Programming mode refuses word access; no fetch from flash allowed.
// - Programming mode returns read data as 16-bit half-words.
// - Programming mode turns command writes into program or erase jobs.
// - Every read corrects any single-bit error per 32-bit word.
// - Programming stores 7 check bits per 32-bit word automatically.
// - Correction adds no read cycles; fixed read latency.
// - Sector erase, chip erase and half-word programming supported.
// - Read/reset command returns the decoder to the read state.
`timescale 1ns/1ns
module flash_access_mode_control #(
  parameter int ADDR_W     = 16,
  parameter int SECT_WORDS = 2048
) (
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic              clk_en,
  input  wire logic              sel_write,
  input  wire logic [1:0]        sel_wdata,
  input  wire logic              req_valid,
  input  wire logic              req_write,
  input  wire logic              req_fetch,
  input  wire logic [1:0]        req_size,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [15:0]       req_wdata,
  output logic      [1:0]        access_size_select,
  output logic                   rom_mode,
  output logic                   prog_mode,
  output logic                   busy,
  output logic                   rsp_valid,
  output logic                   rsp_error,
  output logic                   rsp_corrected,
  output logic      [31:0]       rsp_data
);

  localparam int WORD_AW = ADDR_W - 2;
  localparam logic [WORD_AW-1:0] SECT_MASK = WORD_AW'(SECT_WORDS - 1);
  localparam logic [WORD_AW-1:0] LAST_WORD = '1;

  typedef enum {CMD_IDLE, CMD_UNL1, CMD_UNL2, CMD_PROG_DATA,
                CMD_ERS_UNL0, CMD_ERS_UNL1, CMD_ERS_SEL} cmd_state_t;
  typedef enum {ENG_IDLE, ENG_PROG_RD, ENG_PROG_WR, ENG_ERASE} eng_state_t;

  // ----------------------------------------------------------------
  // Correction code functions
  // ----------------------------------------------------------------
  function automatic logic [38:0] ecc_encode(input logic [31:0] d);
    logic [38:1] h;
    int          k;
    h = '0;
    k = 0;
    for (int i = 1; i <= 38; i++) begin
      if ((i & (i - 1)) != 0) begin
        h[i] = d[k];
        k++;
      end
    end
    for (int p = 0; p < 6; p++) begin
      for (int i = 1; i <= 38; i++) begin
        if (((i >> p) & 1) == 1 && (i & (i - 1)) != 0) begin
          h[1 << p] = h[1 << p] ^ h[i];
        end
      end
    end
    return {^h, h};
  endfunction

  function automatic logic [32:0] ecc_decode(input logic [38:0] cw);
    logic [38:1] h;
    logic [5:0]  s;
    logic [31:0] d;
    int          k;
    h = cw[37:0];
    s = '0;
    d = '0;
    k = 0;
    for (int i = 1; i <= 38; i++) begin
      if (h[i]) begin
        s = s ^ 6'(i);
      end
    end
    if (s != 6'h00 && s <= 6'h26) begin
      h[s] = ~h[s];
    end
    for (int i = 1; i <= 38; i++) begin
      if ((i & (i - 1)) != 0) begin
        d[k] = h[i];
        k++;
      end
    end
    return {s != 6'h00, d};
  endfunction

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  cmd_state_t         cmd_state_reg;
  eng_state_t         eng_state_reg;
  logic [WORD_AW-1:0] prog_word_reg;
  logic               prog_hi_reg;
  logic [15:0]        prog_data_reg;
  logic [WORD_AW-1:0] ers_addr_reg;
  logic [WORD_AW-1:0] ers_last_reg;
  logic               s1_valid_reg;
  logic               s1_err_reg;
  logic               s1_read_reg;
  logic               s1_half_reg;
  logic               s1_hi_reg;
  logic [1:0]         sel_next;
  logic               word_rd_ok;
  logic               half_rd_ok;
  logic               half_wr_ok;
  logic               req_ok;
  logic               host_rd;
  logic               cmd_wr;
  logic               start_prog;
  logic               start_chip;
  logic               start_sect;
  logic [WORD_AW-1:0] req_word;
  logic [15:0]        addr_lo;
  logic [7:0]         code;
  logic               mem_rd_en;
  logic [WORD_AW-1:0] mem_rd_addr;
  logic [38:0]        mem_rd_data;
  logic               mem_wr_en;
  logic [WORD_AW-1:0] mem_wr_addr;
  logic [31:0]        wr_word;
  logic [38:0]        mem_wr_data;
  logic [32:0]        dec;
  logic [31:0]        old_word;

  // ----------------------------------------------------------------
  // Access-size field and mode flags
  // ----------------------------------------------------------------
  always_comb begin
    sel_next = access_size_select;
    if (sel_write && (sel_wdata == flash_access_pkg::SEL_ROM ||
                      sel_wdata == flash_access_pkg::SEL_PROG)) begin
      sel_next = sel_wdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      access_size_select <= flash_access_pkg::SEL_RESET;
      rom_mode           <= 1'b1;
      prog_mode          <= 1'b0;
    end else if (clk_en) begin
      access_size_select <= sel_next;
      rom_mode  <= sel_next == flash_access_pkg::SEL_ROM;
      prog_mode <= sel_next == flash_access_pkg::SEL_PROG;
    end
  end

  // ----------------------------------------------------------------
  // Access checking
  // ----------------------------------------------------------------
  assign word_rd_ok = rom_mode && !req_write &&
                      req_size == flash_access_pkg::SIZE_WORD;
  assign half_rd_ok = prog_mode && !req_write && !req_fetch &&
                      req_size == flash_access_pkg::SIZE_HALF;
  assign half_wr_ok = prog_mode && req_write && !req_fetch &&
                      req_size == flash_access_pkg::SIZE_HALF;
  assign req_ok  = !busy && (word_rd_ok || half_rd_ok || half_wr_ok);
  assign host_rd = clk_en && req_valid && req_ok && !req_write;
  assign cmd_wr  = clk_en && req_valid && req_ok && req_write;
  assign req_word = req_addr[ADDR_W-1:2];
  assign addr_lo  = 16'(req_addr);
  assign code     = req_wdata[7:0];

  // ----------------------------------------------------------------
  // Command decoder
  // ----------------------------------------------------------------
  assign start_prog = cmd_wr && cmd_state_reg == CMD_PROG_DATA &&
                      !req_addr[0] && code != flash_access_pkg::CMD_READRST;
  assign start_chip = cmd_wr && cmd_state_reg == CMD_ERS_SEL &&
                      code == flash_access_pkg::CMD_CHIP &&
                      addr_lo == flash_access_pkg::CMD_ADDR_A;
  assign start_sect = cmd_wr && cmd_state_reg == CMD_ERS_SEL &&
                      code == flash_access_pkg::CMD_SECTOR;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cmd_state_reg <= CMD_IDLE;
    end else if (cmd_wr) begin
      cmd_state_reg <= CMD_IDLE;
      if (code != flash_access_pkg::CMD_READRST) begin
        unique case (cmd_state_reg)
          CMD_IDLE, CMD_ERS_UNL0: begin
            if (code == flash_access_pkg::CMD_UNLOCK1 &&
                addr_lo == flash_access_pkg::CMD_ADDR_A) begin
              cmd_state_reg <= cmd_state_reg == CMD_IDLE ? CMD_UNL1
                                                         : CMD_ERS_UNL1;
            end
          end
          CMD_UNL1, CMD_ERS_UNL1: begin
            if (code == flash_access_pkg::CMD_UNLOCK2 &&
                addr_lo == flash_access_pkg::CMD_ADDR_B) begin
              cmd_state_reg <= cmd_state_reg == CMD_UNL1 ? CMD_UNL2
                                                         : CMD_ERS_SEL;
            end
          end
          CMD_UNL2: begin
            if (addr_lo == flash_access_pkg::CMD_ADDR_A) begin
              if (code == flash_access_pkg::CMD_PROGRAM) begin
                cmd_state_reg <= CMD_PROG_DATA;
              end else if (code == flash_access_pkg::CMD_ERASE) begin
                cmd_state_reg <= CMD_ERS_UNL0;
              end
            end
          end
          CMD_PROG_DATA, CMD_ERS_SEL: begin
            cmd_state_reg <= CMD_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Program and erase engine
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      eng_state_reg <= ENG_IDLE;
      busy          <= 1'b0;
      prog_word_reg <= '0;
      prog_hi_reg   <= 1'b0;
      prog_data_reg <= '0;
      ers_addr_reg  <= '0;
      ers_last_reg  <= '0;
    end else if (clk_en) begin
      unique case (eng_state_reg)
        ENG_IDLE: begin
          if (start_prog) begin
            prog_word_reg <= req_word;
            prog_hi_reg   <= req_addr[1];
            prog_data_reg <= req_wdata;
            eng_state_reg <= ENG_PROG_RD;
            busy          <= 1'b1;
          end else if (start_chip) begin
            ers_addr_reg  <= '0;
            ers_last_reg  <= LAST_WORD;
            eng_state_reg <= ENG_ERASE;
            busy          <= 1'b1;
          end else if (start_sect) begin
            ers_addr_reg  <= req_word & ~SECT_MASK;
            ers_last_reg  <= req_word | SECT_MASK;
            eng_state_reg <= ENG_ERASE;
            busy          <= 1'b1;
          end
        end
        ENG_PROG_RD: begin
          eng_state_reg <= ENG_PROG_WR;
        end
        ENG_PROG_WR: begin
          eng_state_reg <= ENG_IDLE;
          busy          <= 1'b0;
        end
        ENG_ERASE: begin
          if (ers_addr_reg == ers_last_reg) begin
            eng_state_reg <= ENG_IDLE;
            busy          <= 1'b0;
          end else begin
            ers_addr_reg <= ers_addr_reg + 1'b1;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Array access and code generation
  // ----------------------------------------------------------------
  assign dec      = ecc_decode(mem_rd_data);
  assign old_word = dec[31:0];
  always_comb begin
    wr_word = flash_access_pkg::ERASED_WORD;
    if (eng_state_reg == ENG_PROG_WR) begin
      wr_word = old_word;
      if (prog_hi_reg) begin
        wr_word[31:16] = old_word[31:16] & prog_data_reg;
      end else begin
        wr_word[15:0] = old_word[15:0] & prog_data_reg;
      end
    end
  end
  assign mem_wr_data = ecc_encode(wr_word);
  assign mem_wr_en   = eng_state_reg == ENG_PROG_WR ||
                       eng_state_reg == ENG_ERASE;
  assign mem_wr_addr = eng_state_reg == ENG_ERASE ? ers_addr_reg
                                                  : prog_word_reg;
  assign mem_rd_en   = host_rd || eng_state_reg == ENG_PROG_RD;
  assign mem_rd_addr = eng_state_reg == ENG_PROG_RD ? prog_word_reg
                                                    : req_word;

  flash_array #(
    .WIDTH  (flash_access_pkg::CW_W),
    .ADDR_W (WORD_AW)
  ) u_array (
    .ref_clk (ref_clk),
    .rst     (rst),
    .clk_en  (clk_en),
    .rd_en   (mem_rd_en),
    .rd_addr (mem_rd_addr),
    .rd_data (mem_rd_data),
    .wr_en   (mem_wr_en && clk_en),
    .wr_addr (mem_wr_addr),
    .wr_data (mem_wr_data)
  );

  // ----------------------------------------------------------------
  // Response pipeline
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s1_valid_reg <= 1'b0;
      s1_err_reg   <= 1'b0;
      s1_read_reg  <= 1'b0;
      s1_half_reg  <= 1'b0;
      s1_hi_reg    <= 1'b0;
    end else if (clk_en) begin
      s1_valid_reg <= req_valid;
      s1_err_reg   <= req_valid && !req_ok;
      s1_read_reg  <= host_rd;
      s1_half_reg  <= half_rd_ok;
      s1_hi_reg    <= req_addr[1];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rsp_valid     <= 1'b0;
      rsp_error     <= 1'b0;
      rsp_corrected <= 1'b0;
      rsp_data      <= '0;
    end else if (clk_en) begin
      rsp_valid     <= s1_valid_reg;
      rsp_error     <= s1_err_reg;
      rsp_corrected <= s1_read_reg && dec[32];
      rsp_data      <= '0;
      if (s1_read_reg) begin
        if (s1_half_reg) begin
          rsp_data <= {16'h0000, s1_hi_reg ? old_word[31:16]
                                           : old_word[15:0]};
        end else begin
          rsp_data <= old_word;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_reset_rom_mode: assert property (disable iff (1'b0)
    rst |=> access_size_select == flash_access_pkg::SEL_ROM && rom_mode)
    else $error("reset did not restore read-only mode");
  a_rom_word_read: assert property (
    (clk_en && req_valid && rom_mode && !busy && !req_write &&
     req_size == flash_access_pkg::SIZE_WORD) ##1 clk_en ##1 clk_en
    |-> rsp_valid && !rsp_error)
    else $error("word read in read-only mode not answered");
  a_prog_half_ok: assert property (
    (clk_en && req_valid && half_rd_ok && !busy) |=> s1_read_reg)
    else $error("half read in programming mode not taken");
  a_rom_no_cmd: assert property (
    (rom_mode && !busy) |=> !busy)
    else $error("engine started in read-only mode");
  a_prog_word_refused: assert property (
    (clk_en && req_valid && prog_mode &&
     (req_fetch || req_size == flash_access_pkg::SIZE_WORD))
    ##1 clk_en ##1 clk_en |-> rsp_error)
    else $error("word access accepted in programming mode");
  a_half_zero_ext: assert property (
    (clk_en && s1_read_reg && s1_half_reg) |=> rsp_data[31:16] == 16'h0000)
    else $error("half read not in low half-word");
  a_prog_start: assert property (
    start_prog && clk_en |=> busy ##1 (eng_state_reg == ENG_PROG_WR ||
                                       !clk_en))
    else $error("program command did not start engine");
  a_ecc_single_fix: assert property (
    mem_wr_en |-> ecc_decode(mem_wr_data ^ 39'h000000100) ==
                  {1'b1, wr_word})
    else $error("single-bit error not corrected");
  a_read_latency: assert property (
    (clk_en && s1_valid_reg) |=> rsp_valid)
    else $error("read answer late");
  a_erase_bounds: assert property (
    eng_state_reg == ENG_ERASE |-> ers_addr_reg <= ers_last_reg)
    else $error("erase walked past its range");
  a_read_reset_cmd: assert property (
    (cmd_wr && code == flash_access_pkg::CMD_READRST)
    |=> cmd_state_reg == CMD_IDLE && !busy)
    else $error("read/reset did not return to read state");
  a_reserved_sel: assert property (
    (clk_en && sel_write && sel_wdata != flash_access_pkg::SEL_ROM &&
     sel_wdata != flash_access_pkg::SEL_PROG) |=> $stable(access_size_select))
    else $error("reserved access size changed the mode");

  c_rom_read: cover property (host_rd && rom_mode);
  c_program: cover property (start_prog ##[1:4] !busy);
  c_chip_erase: cover property (start_chip);
  c_corrected: cover property (rsp_corrected);

endmodule

/* File: flash_access_pkg.sv */
package flash_access_pkg;

  // ----------------------------------------------------------------
  // Access-size field encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] SEL_ROM   = 2'h2;
  localparam logic [1:0] SEL_PROG  = 2'h1;
  localparam logic [1:0] SEL_RESET = SEL_ROM;

  // ----------------------------------------------------------------
  // Request size codes
  // ----------------------------------------------------------------
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;

  // ----------------------------------------------------------------
  // Widths of data and correction code
  // ----------------------------------------------------------------
  localparam int DATA_W  = 32;
  localparam int HALF_W  = 16;
  localparam int CHECK_W = 7;
  localparam int CW_W    = DATA_W + CHECK_W;
  localparam int HAM_W   = CW_W - 1;
  localparam int SYN_W   = 6;
  localparam int READ_LATENCY = 2;

  // ----------------------------------------------------------------
  // Command addresses (low 16 bits) and codes (low 8 bits)
  // ----------------------------------------------------------------
  localparam logic [15:0] CMD_ADDR_A  = 16'h1550;
  localparam logic [15:0] CMD_ADDR_B  = 16'h0aa8;
  localparam logic [7:0]  CMD_UNLOCK1 = 8'haa;
  localparam logic [7:0]  CMD_UNLOCK2 = 8'h55;
  localparam logic [7:0]  CMD_PROGRAM = 8'ha0;
  localparam logic [7:0]  CMD_ERASE   = 8'h80;
  localparam logic [7:0]  CMD_CHIP    = 8'h10;
  localparam logic [7:0]  CMD_SECTOR  = 8'h30;
  localparam logic [7:0]  CMD_READRST = 8'hf0;

  // ----------------------------------------------------------------
  // Erased word value
  // ----------------------------------------------------------------
  localparam logic [31:0] ERASED_WORD = 32'hffffffff;

endpackage

/* File: flash_array.sv */
`timescale 1ns/1ns
module flash_array #(
  parameter int WIDTH  = 39,
  parameter int ADDR_W = 14
) (
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic              clk_en,
  input  wire logic              rd_en,
  input  wire logic [ADDR_W-1:0] rd_addr,
  output logic      [WIDTH-1:0]  rd_data,
  input  wire logic              wr_en,
  input  wire logic [ADDR_W-1:0] wr_addr,
  input  wire logic [WIDTH-1:0]  wr_data
);

  // ----------------------------------------------------------------
  // Cell storage
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] cells [0:(1<<ADDR_W)-1];

  always_ff @(posedge ref_clk) begin
    if (clk_en && wr_en) begin
      cells[wr_addr] <= wr_data;
    end
  end

  // ----------------------------------------------------------------
  // Registered read port
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rd_data <= '0;
    end else if (clk_en && rd_en) begin
      rd_data <= cells[rd_addr];
    end
  end

endmodule

/* File: core_model.sv */
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Core model issuing flash requests
// ----------------------------------------------------------------
module core_model (
  input  wire logic        ref_clk,
  input  wire logic        rsp_valid,
  input  wire logic        rsp_error,
  input  wire logic        rsp_corrected,
  input  wire logic [31:0] rsp_data,
  output logic             req_valid,
  output logic             req_write,
  output logic             req_fetch,
  output logic      [1:0]  req_size,
  output logic      [15:0] req_addr,
  output logic      [15:0] req_wdata
);
  initial begin
    req_valid = 1'b0;
    req_write = 1'b0;
    req_fetch = 1'b0;
    req_size  = 2'h0;
    req_addr  = 16'h0000;
    req_wdata = 16'h0000;
  end

  // One request, answer taken two edges later
  task automatic access(
    input  logic        w,
    input  logic        f,
    input  logic [1:0]  sz,
    input  logic [15:0] a,
    input  logic [15:0] d,
    output logic        err,
    output logic        corr,
    output logic        ok,
    output logic [31:0] data
  );
    logic early;
    @(negedge ref_clk);
    req_valid = 1'b1;
    req_write = w;
    req_fetch = f;
    req_size  = sz;
    req_addr  = a;
    req_wdata = d;
    @(negedge ref_clk);
    req_valid = 1'b0;
    req_addr  = ~a;
    req_wdata = ~d;
    early = rsp_valid;
    @(negedge ref_clk);
    ok   = !early && rsp_valid;
    err  = rsp_error;
    corr = rsp_corrected;
    data = rsp_data;
  endtask
endmodule

/* File: tb_top.sv */
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Testbench
// ----------------------------------------------------------------
module tb_top;
  logic        ref_clk   = 1'b0;
  logic        rst       = 1'b1;
  logic        clk_en    = 1'b1;
  logic        sel_write = 1'b0;
  logic [1:0]  sel_wdata = 2'h0;
  logic        req_valid;
  logic        req_write;
  logic        req_fetch;
  logic [1:0]  req_size;
  logic [15:0] req_addr;
  logic [15:0] req_wdata;
  logic [1:0]  access_size_select;
  logic        rom_mode;
  logic        prog_mode;
  logic        busy;
  logic        rsp_valid;
  logic        rsp_error;
  logic        rsp_corrected;
  logic [31:0] rsp_data;
  logic        err;
  logic        corr;
  logic        ok;
  logic [31:0] data;
  int          mismatches = 0;
  int          cmp_count  = 0;

  always #50 ref_clk = ~ref_clk;

  flash_access_mode_control #(.ADDR_W(16), .SECT_WORDS(2048)) DUT (
    .ref_clk(ref_clk), .rst(rst), .clk_en(clk_en),
    .sel_write(sel_write), .sel_wdata(sel_wdata),
    .req_valid(req_valid), .req_write(req_write), .req_fetch(req_fetch),
    .req_size(req_size), .req_addr(req_addr), .req_wdata(req_wdata),
    .access_size_select(access_size_select), .rom_mode(rom_mode),
    .prog_mode(prog_mode), .busy(busy), .rsp_valid(rsp_valid),
    .rsp_error(rsp_error), .rsp_corrected(rsp_corrected),
    .rsp_data(rsp_data));

  core_model core (
    .ref_clk(ref_clk), .rsp_valid(rsp_valid), .rsp_error(rsp_error),
    .rsp_corrected(rsp_corrected), .rsp_data(rsp_data),
    .req_valid(req_valid), .req_write(req_write), .req_fetch(req_fetch),
    .req_size(req_size), .req_addr(req_addr), .req_wdata(req_wdata));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input string nm, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("Comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic wait_idle(input int n);
    int i;
    for (i = 0; i < n && busy !== 1'b0; i++) begin
      @(negedge ref_clk);
    end
    if (busy !== 1'b0) begin
      mismatches++;
      $display("ERROR busy expected 0 seen %b", busy);
      complete_run();
    end
  endtask

  task automatic set_sel(input logic [1:0] v);
    @(negedge ref_clk);
    sel_write = 1'b1;
    sel_wdata = v;
    @(negedge ref_clk);
    sel_write = 1'b0;
    sel_wdata = ~v;
  endtask

  task automatic mode(input logic [1:0] m);
    check("access_size_select", access_size_select, m);
    check("rom_mode", rom_mode, m == flash_access_pkg::SEL_ROM);
    check("prog_mode", prog_mode, m == flash_access_pkg::SEL_PROG);
  endtask

  task automatic wr(input logic [15:0] a, d, input logic xe);
    core.access(1'b1, 1'b0, flash_access_pkg::SIZE_HALF, a, d,
                err, corr, ok, data);
    check("write_error", err, xe);
    check("write_data", data, 32'h0);
  endtask

  task automatic rd(input logic f, input logic [1:0] sz,
                    input logic [15:0] a, input logic xe,
                    input logic [31:0] xd);
    core.access(1'b0, f, sz, a, 16'h0000, err, corr, ok, data);
    check("latency", ok, 1'b1);
    check("read_error", err, xe);
    check("read_data", data, xd);
    if (!xe) begin
      check("corrected", corr, 1'b0);
    end
  endtask

  task automatic op(input logic [15:0] a, input logic [7:0] c,
                    input logic xe);
    wr(a, {8'h5a, c}, xe);
  endtask

  task automatic unlock(input logic xe);
    op(flash_access_pkg::CMD_ADDR_A, flash_access_pkg::CMD_UNLOCK1, xe);
    op(flash_access_pkg::CMD_ADDR_B, flash_access_pkg::CMD_UNLOCK2, xe);
  endtask

  task automatic erase_head();
    unlock(1'b0);
    op(flash_access_pkg::CMD_ADDR_A, flash_access_pkg::CMD_ERASE, 1'b0);
    unlock(1'b0);
  endtask

  task automatic program_half(input logic [15:0] a, d, input logic xe);
    unlock(xe);
    op(flash_access_pkg::CMD_ADDR_A, flash_access_pkg::CMD_PROGRAM, xe);
    wr(a, d, xe);
    wait_idle(10);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    @(negedge ref_clk);
    rst = 1'b1;
    repeat (4) @(negedge ref_clk);
    rst = 1'b0;
    mode(flash_access_pkg::SEL_RESET);
    check("busy", busy, 1'b0);
    $display("Test reset done");
  endtask

  task automatic t_prog();
    set_sel(flash_access_pkg::SEL_PROG);
    mode(flash_access_pkg::SEL_PROG);
    set_sel(2'h3);
    mode(flash_access_pkg::SEL_PROG);
    clk_en = 1'b0;
    set_sel(flash_access_pkg::SEL_ROM);
    mode(flash_access_pkg::SEL_PROG);
    clk_en = 1'b1;
    rd(1'b0, flash_access_pkg::SIZE_WORD, 16'h0010, 1'b1, 32'h0);
    rd(1'b1, flash_access_pkg::SIZE_HALF, 16'h0010, 1'b1, 32'h0);
    $display("Test programming mode done");
  endtask

  task automatic t_chip();
    erase_head();
    op(flash_access_pkg::CMD_ADDR_A, flash_access_pkg::CMD_CHIP, 1'b0);
    check("busy", busy, 1'b1);
    rd(1'b0, flash_access_pkg::SIZE_HALF, 16'h0010, 1'b1, 32'h0);
    wait_idle(20000);
    rd(1'b0, flash_access_pkg::SIZE_HALF, 16'h0012, 1'b0, 32'hffff);
    $display("Test chip erase done");
  endtask

  task automatic t_program();
    program_half(16'h0010, 16'h1234, 1'b0);
    rd(1'b0, flash_access_pkg::SIZE_HALF, 16'h0010, 1'b0, 32'h1234);
    unlock(1'b0);
    op(flash_access_pkg::CMD_ADDR_A, flash_access_pkg::CMD_PROGRAM, 1'b0);
    op(16'h0100, flash_access_pkg::CMD_READRST, 1'b0);
    wr(16'h0012, 16'h0000, 1'b0);
    check("busy", busy, 1'b0);
    rd(1'b0, flash_access_pkg::SIZE_HALF, 16'h0012, 1'b0, 32'hffff);
    program_half(16'h0012, 16'habcd, 1'b0);
    rd(1'b0, flash_access_pkg::SIZE_HALF, 16'h0012, 1'b0, 32'habcd);
    $display("Test program done");
  endtask

  task automatic t_rom();
    set_sel(flash_access_pkg::SEL_ROM);
    set_sel(2'h0);
    mode(flash_access_pkg::SEL_ROM);
    rd(1'b0, flash_access_pkg::SIZE_WORD, 16'h0010, 1'b0, 32'habcd1234);
    rd(1'b1, flash_access_pkg::SIZE_WORD, 16'h0010, 1'b0, 32'habcd1234);
    rd(1'b0, flash_access_pkg::SIZE_HALF, 16'h0010, 1'b1, 32'h0);
    program_half(16'h0010, 16'h0000, 1'b1);
    check("busy", busy, 1'b0);
    rd(1'b0, flash_access_pkg::SIZE_WORD, 16'h0010, 1'b0, 32'habcd1234);
    $display("Test read-only mode done");
  endtask

  task automatic t_sector();
    set_sel(flash_access_pkg::SEL_PROG);
    erase_head();
    op(16'h0014, flash_access_pkg::CMD_SECTOR, 1'b0);
    check("busy", busy, 1'b1);
    wait_idle(5000);
    rd(1'b0, flash_access_pkg::SIZE_HALF, 16'h0012, 1'b0, 32'hffff);
    $display("Test sector erase done");
  endtask

  initial begin
    t_reset();
    t_prog();
    t_chip();
    t_program();
    t_rom();
    t_sector();
    t_reset();
    complete_run();
  end
endmodule
